// >>> logic/csc_pkg.sv
// Constants, types and shared functions for the colour-space converter.
`default_nettype none
package csc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CODEC_BASE = 8'h00;
    localparam logic [7:0] OFS_Y2R_A = 8'h04;
    localparam logic [7:0] OFS_Y2R_B = 8'h08;
    localparam logic [7:0] OFS_R2Y_A = 8'h0C;
    localparam logic [7:0] OFS_R2Y_B = 8'h10;
    localparam logic [7:0] OFS_R2Y_C = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [31:0] RST_CODEC_BASE = 32'h00000000;
    localparam logic [31:0] RST_Y2R_A = 32'h6832CC95;
    localparam logic [31:0] RST_Y2R_B = 32'h00007102;
    localparam logic [31:0] RST_R2Y_A = 32'h01324145;
    localparam logic [31:0] RST_R2Y_B = 32'h01245E38;
    localparam logic [31:0] RST_R2Y_C = 32'h01384A4B;
    localparam logic [31:0] RST_CTRL = 32'h00000000;
    localparam logic [31:0] MASK_Y2R_B = 32'h000071FF;
    localparam logic [31:0] MASK_R2Y = 32'h01FFFFFF;
    localparam logic [31:0] MASK_CTRL = 32'h00000001;
    localparam int CTRL_DIR_BIT = 0;
    localparam int COEF4_MSB = 8;
    localparam int YOFF_BIT = 12;
    localparam int CROFF_BIT = 13;
    localparam int CBOFF_BIT = 14;
    localparam int RGB_OFF_BIT = 24;
    localparam int Y2R_FRAC = 7;
    localparam int R2Y_FRAC = 9;
    localparam int SHIFT_128 = 2;
    localparam int SHIFT_256 = 1;
    localparam int SHIFT_512 = 0;
    localparam logic signed [23:0] OFF_16 = 24'sh000010;
    localparam logic signed [23:0] OFF_128 = 24'sh000080;
    localparam logic signed [23:0] PIX_MAX = 24'sh0000FF;
    localparam logic [31:0] ADDR_STEP = 32'h00000004;
    localparam int CNT_W = 16;

    typedef enum logic {DIR_Y2R, DIR_R2Y} dir_t;

    // Merges write data into a register under the byte strobes.
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // Signed sample times unsigned coefficient.
    function automatic logic signed [23:0] mul(input logic signed [23:0] a, input logic [10:0] c);
        return a * $signed({13'h0000, c});
    endfunction

    // Brings a byte coefficient to a common step of one 512th.
    function automatic logic [10:0] scl(input logic [7:0] c, input int sh);
        return 11'({3'h0, c} << sh);
    endfunction

    // Clamps a signed value to the 8-bit pixel range.
    function automatic logic [7:0] sat8(input logic signed [23:0] v);
        if (v < 0)
        begin
            return 8'h00;
        end
        else if (v > PIX_MAX)
        begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction
endpackage
`default_nettype wire

// >>> logic/pixel_color_space_converter.sv
// Colour-space converter datapath with its APB register file.
//
// What this block does
// - Software writes a codec buffer start address that seeds the codec output address in RGB-to-YCrCb direction only.
// - The four YCrCb-to-RGB byte coefficients count in steps of 1/128, from 0 to 1.9921875.
// - The fifth YCrCb-to-RGB coefficient is nine bits wide in steps of 1/128, up to 3.9921875.
// - A set luminance offset bit takes 128 off luminance, a clear one nothing.
// - A set red chrominance offset bit takes 16 off red chrominance, a clear one nothing.
// - A set blue chrominance offset bit takes 16 off blue chrominance, a clear one nothing.
// - The first RGB-to-YCrCb coefficient counts in steps of 1/256 in bits 7 to 0.
// - The second RGB-to-YCrCb coefficient counts in steps of 1/128 in bits 15 to 8.
// - The third RGB-to-YCrCb coefficient counts in steps of 1/512 in bits 23 to 16.
// - A set red component offset bit adds 16 to the luminance result.
// - The second RGB set holds coefficients of step 1/128, 1/256 and 1/512 from low to high.
// - A set green component offset bit adds 128 to the red chrominance result.
// - The third RGB set holds coefficients of step 1/512, 1/256 and 1/128 from low to high.
// - A set blue component offset bit adds 128 to the blue chrominance result.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pixel_color_space_converter (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [csc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_frame_start,
    input wire logic i_pix_valid,
    input wire logic [7:0] i_pix_0,
    input wire logic [7:0] i_pix_1,
    input wire logic [7:0] i_pix_2,
    output logic o_pix_valid,
    output logic [7:0] o_pix_0,
    output logic [7:0] o_pix_1,
    output logic [7:0] o_pix_2,
    output logic [31:0] o_codec_addr,
    output logic o_dir_r2y
);
    import csc_pkg::*;

    logic [31:0] codec_base_q, codec_base_d, y2r_a_q, y2r_a_d, y2r_b_q, y2r_b_d;
    logic [31:0] r2y_a_q, r2y_a_d, r2y_b_q, r2y_b_d, r2y_c_q, r2y_c_d, ctrl_q, ctrl_d;
    logic [31:0] prdata_q, prdata_d, rd_data;
    logic hit, wr;
    logic [CNT_W-1:0] count_q, count_d;
    logic [31:0] next_addr_q, next_addr_d, out_addr_q, out_addr_d, cur_addr;
    logic valid_q, valid_d;
    logic [7:0] pix0_q, pix0_d, pix1_q, pix1_d, pix2_q, pix2_d;
    dir_t dir;
    logic signed [23:0] ys, crs, cbs, rs, gs, bs;
    logic signed [23:0] r_sum, g_sum, b_sum, yy_sum, cr_sum, cb_sum;
    logic [7:0] res0, res1, res2;

    // Address decode and read mux.
    always_comb
    begin
        hit = 1'b1;
        rd_data = 32'h00000000;
        if (i_paddr == OFS_CODEC_BASE)
            rd_data = codec_base_q;
        else if (i_paddr == OFS_Y2R_A)
            rd_data = y2r_a_q;
        else if (i_paddr == OFS_Y2R_B)
            rd_data = y2r_b_q;
        else if (i_paddr == OFS_R2Y_A)
            rd_data = r2y_a_q;
        else if (i_paddr == OFS_R2Y_B)
            rd_data = r2y_b_q;
        else if (i_paddr == OFS_R2Y_C)
            rd_data = r2y_c_q;
        else if (i_paddr == OFS_CTRL)
            rd_data = ctrl_q;
        else if (i_paddr == OFS_STATUS)
            rd_data = {16'h0000, count_q};
        else
            hit = 1'b0;
    end

    assign wr = i_psel & i_penable & i_pwrite & hit;
    assign o_pready = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~hit;
    assign o_prdata = prdata_q;

    // Register writes in the access cycle and read data capture in the setup cycle.
    always_comb
    begin
        prdata_d = (i_psel & ~i_penable & ~i_pwrite) ? rd_data : prdata_q;
        codec_base_d = (wr && i_paddr == OFS_CODEC_BASE) ?
            strb_merge(codec_base_q, i_pwdata, i_pstrb, 32'hFFFFFFFF) : codec_base_q;
        y2r_a_d = (wr && i_paddr == OFS_Y2R_A) ?
            strb_merge(y2r_a_q, i_pwdata, i_pstrb, 32'hFFFFFFFF) : y2r_a_q;
        y2r_b_d = (wr && i_paddr == OFS_Y2R_B) ?
            strb_merge(y2r_b_q, i_pwdata, i_pstrb, MASK_Y2R_B) : y2r_b_q;
        r2y_a_d = (wr && i_paddr == OFS_R2Y_A) ?
            strb_merge(r2y_a_q, i_pwdata, i_pstrb, MASK_R2Y) : r2y_a_q;
        r2y_b_d = (wr && i_paddr == OFS_R2Y_B) ?
            strb_merge(r2y_b_q, i_pwdata, i_pstrb, MASK_R2Y) : r2y_b_q;
        r2y_c_d = (wr && i_paddr == OFS_R2Y_C) ?
            strb_merge(r2y_c_q, i_pwdata, i_pstrb, MASK_R2Y) : r2y_c_q;
        ctrl_d = (wr && i_paddr == OFS_CTRL) ?
            strb_merge(ctrl_q, i_pwdata, i_pstrb, MASK_CTRL) : ctrl_q;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prdata_q <= 32'h00000000;
            codec_base_q <= RST_CODEC_BASE;
            y2r_a_q <= RST_Y2R_A;
            y2r_b_q <= RST_Y2R_B;
            r2y_a_q <= RST_R2Y_A;
            r2y_b_q <= RST_R2Y_B;
            r2y_c_q <= RST_R2Y_C;
            ctrl_q <= RST_CTRL;
        end
        else
        begin
            prdata_q <= prdata_d;
            codec_base_q <= codec_base_d;
            y2r_a_q <= y2r_a_d;
            y2r_b_q <= y2r_b_d;
            r2y_a_q <= r2y_a_d;
            r2y_b_q <= r2y_b_d;
            r2y_c_q <= r2y_c_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign dir = ctrl_q[CTRL_DIR_BIT] ? DIR_R2Y : DIR_Y2R;
    assign o_dir_r2y = ctrl_q[CTRL_DIR_BIT];

    // Conversion arithmetic for both directions.
    always_comb
    begin
        ys = $signed({16'h0000, i_pix_0}) - (y2r_b_q[YOFF_BIT] ? OFF_128 : 24'sh000000);
        crs = $signed({16'h0000, i_pix_1}) - (y2r_b_q[CROFF_BIT] ? OFF_16 : 24'sh000000);
        cbs = $signed({16'h0000, i_pix_2}) - (y2r_b_q[CBOFF_BIT] ? OFF_16 : 24'sh000000);
        r_sum = mul(ys, scl(y2r_a_q[7:0], 0)) + mul(crs, scl(y2r_a_q[15:8], 0));
        g_sum = mul(ys, scl(y2r_a_q[7:0], 0)) - mul(crs, scl(y2r_a_q[23:16], 0))
              - mul(cbs, scl(y2r_a_q[31:24], 0));
        b_sum = mul(ys, scl(y2r_a_q[7:0], 0)) + mul(cbs, {2'b00, y2r_b_q[COEF4_MSB:0]});
        rs = $signed({16'h0000, i_pix_0});
        gs = $signed({16'h0000, i_pix_1});
        bs = $signed({16'h0000, i_pix_2});
        yy_sum = mul(rs, scl(r2y_a_q[7:0], SHIFT_256)) + mul(gs, scl(r2y_a_q[15:8], SHIFT_128))
               + mul(bs, scl(r2y_a_q[23:16], SHIFT_512));
        cr_sum = mul(rs, scl(r2y_b_q[7:0], SHIFT_128)) - mul(gs, scl(r2y_b_q[15:8], SHIFT_256))
               - mul(bs, scl(r2y_b_q[23:16], SHIFT_512));
        cb_sum = mul(bs, scl(r2y_c_q[23:16], SHIFT_128)) - mul(gs, scl(r2y_c_q[15:8], SHIFT_256))
               - mul(rs, scl(r2y_c_q[7:0], SHIFT_512));
        case (dir)
            DIR_Y2R:
            begin
                res0 = sat8(r_sum >>> Y2R_FRAC);
                res1 = sat8(g_sum >>> Y2R_FRAC);
                res2 = sat8(b_sum >>> Y2R_FRAC);
            end
            default:
            begin
                res0 = sat8((yy_sum >>> R2Y_FRAC)
                     + (r2y_a_q[RGB_OFF_BIT] ? OFF_16 : 24'sh000000));
                res1 = sat8((cr_sum >>> R2Y_FRAC)
                     + (r2y_b_q[RGB_OFF_BIT] ? OFF_128 : 24'sh000000));
                res2 = sat8((cb_sum >>> R2Y_FRAC)
                     + (r2y_c_q[RGB_OFF_BIT] ? OFF_128 : 24'sh000000));
            end
        endcase
    end

    // Output stage, pixel count and codec address.
    always_comb
    begin
        valid_d = i_pix_valid;
        pix0_d = i_pix_valid ? res0 : pix0_q;
        pix1_d = i_pix_valid ? res1 : pix1_q;
        pix2_d = i_pix_valid ? res2 : pix2_q;
        count_d = i_frame_start ? {CNT_W{1'b0}} : count_q;
        if (i_pix_valid)
            count_d = count_d + 16'h0001;
        cur_addr = i_frame_start ? codec_base_q : next_addr_q;
        next_addr_d = cur_addr;
        out_addr_d = out_addr_q;
        if (i_pix_valid && dir == DIR_R2Y)
        begin
            out_addr_d = cur_addr;
            next_addr_d = cur_addr + ADDR_STEP;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            valid_q <= 1'b0;
            pix0_q <= 8'h00;
            pix1_q <= 8'h00;
            pix2_q <= 8'h00;
            count_q <= {CNT_W{1'b0}};
            next_addr_q <= RST_CODEC_BASE;
            out_addr_q <= RST_CODEC_BASE;
        end
        else
        begin
            valid_q <= valid_d;
            pix0_q <= pix0_d;
            pix1_q <= pix1_d;
            pix2_q <= pix2_d;
            count_q <= count_d;
            next_addr_q <= next_addr_d;
            out_addr_q <= out_addr_d;
        end
    end

    assign o_pix_valid = valid_q;
    assign o_pix_0 = pix0_q;
    assign o_pix_1 = pix1_q;
    assign o_pix_2 = pix2_q;
    assign o_codec_addr = out_addr_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic y2r_in, r2y_in, no_y2r_off;
    assign y2r_in = i_pix_valid && dir == DIR_Y2R;
    assign r2y_in = i_pix_valid && dir == DIR_R2Y;
    assign no_y2r_off = !y2r_b_q[YOFF_BIT] && !y2r_b_q[CROFF_BIT] && !y2r_b_q[CBOFF_BIT];

    codec_addr_seed_a: assert property (i_frame_start && r2y_in ##1 1'b1 |->
        o_codec_addr == $past(codec_base_q) && o_pix_valid)
        else $error("codec address not seeded from base");
    y2r_grey_a: assert property (y2r_in && no_y2r_off && i_pix_1 == 8'h00
        && i_pix_2 == 8'h00 |=> o_pix_0 == o_pix_1 && o_pix_1 == o_pix_2)
        else $error("grey input gave unequal colours");
    luma_offset_a: assert property (y2r_in && y2r_b_q[YOFF_BIT] && i_pix_0 == 8'h80
        && !y2r_b_q[CROFF_BIT] && !y2r_b_q[CBOFF_BIT] && i_pix_1 == 8'h00 && i_pix_2 == 8'h00
        |=> o_pix_0 == 8'h00 && o_pix_1 == 8'h00 && o_pix_2 == 8'h00)
        else $error("luminance offset not removed");
    cr_offset_a: assert property (y2r_in && y2r_b_q[CROFF_BIT] && !y2r_b_q[YOFF_BIT]
        && !y2r_b_q[CBOFF_BIT] && i_pix_0 == 8'h00 && i_pix_1 == 8'h10 && i_pix_2 == 8'h00
        |=> o_pix_0 == 8'h00)
        else $error("red chrominance offset not removed");
    cb_offset_a: assert property (y2r_in && y2r_b_q[CBOFF_BIT] && !y2r_b_q[YOFF_BIT]
        && !y2r_b_q[CROFF_BIT] && i_pix_0 == 8'h00 && i_pix_1 == 8'h00 && i_pix_2 == 8'h10
        |=> o_pix_2 == 8'h00)
        else $error("blue chrominance offset not removed");
    y2r_clamp_a: assert property (y2r_in && no_y2r_off && i_pix_0 == 8'hFF
        && i_pix_1 == 8'h00 && y2r_a_q[7] |=> o_pix_0 == 8'hFF)
        else $error("red result not clamped");
    // luminance gets its offset on black.
    r2y_roff_a: assert property (r2y_in && {i_pix_0, i_pix_1, i_pix_2} == 24'h000000
        |=> o_pix_0 == (r2y_a_q[RGB_OFF_BIT] ? 8'h10 : 8'h00))
        else $error("luminance offset wrong");
    r2y_goff_a: assert property (r2y_in && {i_pix_0, i_pix_1, i_pix_2} == 24'h000000
        |=> o_pix_1 == (r2y_b_q[RGB_OFF_BIT] ? 8'h80 : 8'h00))
        else $error("red chrominance offset wrong");
    r2y_boff_a: assert property (r2y_in && {i_pix_0, i_pix_1, i_pix_2} == 24'h000000
        |=> o_pix_2 == (r2y_c_q[RGB_OFF_BIT] ? 8'h80 : 8'h00))
        else $error("blue chrominance offset wrong");
    // result held until the next pixel.
    out_hold_a: assert property (!i_pix_valid ##1 !i_pix_valid |->
        $stable(o_pix_0) && !o_pix_valid)
        else $error("output changed without a pixel");

    y2r_pixel_c: cover property (y2r_in ##1 o_pix_valid);
    r2y_pixel_c: cover property (r2y_in ##1 o_pix_valid);
    apb_write_c: cover property (wr);
    apb_error_c: cover property (o_pslverr);
endmodule // pixel_color_space_converter
`default_nettype wire

// >>> dv/pixel_feed_model.sv
// Far-side model: capture path feeding samples and codec path collecting results.
`timescale 1ns/1ps
`default_nettype none
module pixel_feed_model (
    input wire logic i_clk,
    output logic o_frame_start,
    output logic o_valid,
    output logic [7:0] o_p0,
    output logic [7:0] o_p1,
    output logic [7:0] o_p2,
    input wire logic i_res_valid,
    input wire logic [7:0] i_r0,
    input wire logic [7:0] i_r1,
    input wire logic [7:0] i_r2,
    input wire logic [31:0] i_addr
);
    logic [55:0] res_q [$];

    initial
    begin
        o_frame_start = 1'b0;
        o_valid = 1'b0;
        {o_p0, o_p1, o_p2} = 24'h000000;
    end

    // Presents one sample for one cycle; calls may follow back to back.
    task automatic send(input logic f, input logic [23:0] d);
        @(posedge i_clk);
        o_frame_start <= f;
        o_valid <= 1'b1;
        {o_p0, o_p1, o_p2} <= d;
    endtask

    // Ends a burst; released data lines show the inverse of the last value.
    task automatic stop;
        @(posedge i_clk);
        o_frame_start <= 1'b0;
        o_valid <= 1'b0;
        {o_p0, o_p1, o_p2} <= ~{o_p0, o_p1, o_p2};
    endtask

    // Collects every result sample with its codec address.
    always @(posedge i_clk)
    begin
        if (i_res_valid === 1'b1)
        begin
            res_q.push_back({i_r0, i_r1, i_r2, i_addr});
        end
    end
endmodule // pixel_feed_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the colour-space converter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import csc_pkg::*;
    logic i_clk, i_rst_n, psel, pen, pwr, fs, pv, rv, pready, pslverr, dir, err;
    logic [7:0] paddr, p0, p1, p2, r0, r1, r2;
    logic [31:0] pwdata, prdata, caddr, rd;
    logic [3:0] pstrb;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [7:0] ofs [6] = '{OFS_CODEC_BASE, OFS_Y2R_A, OFS_Y2R_B, OFS_R2Y_A, OFS_R2Y_B, OFS_R2Y_C};
    logic [31:0] rst [6] = '{32'h0, 32'h6832CC95, 32'h00007102, 32'h01324145, 32'h01245E38,
                             32'h01384A4B};
    logic [31:0] ones [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000071FF, 32'h01FFFFFF,
                              32'h01FFFFFF, 32'h01FFFFFF};
    logic [31:0] cur [6];
    logic [23:0] vec [10] = '{24'h801010, 24'hFFFFFF, 24'h000000, 24'hC86432, 24'h10F010,
                              24'h4080C0, 24'h800000, 24'h001000, 24'h000010, 24'hFF0000};

    pixel_color_space_converter pixel_color_space_converter_inst (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_frame_start(fs), .i_pix_valid(pv), .i_pix_0(p0), .i_pix_1(p1),
        .i_pix_2(p2), .o_pix_valid(rv), .o_pix_0(r0), .o_pix_1(r1), .o_pix_2(r2),
        .o_codec_addr(caddr), .o_dir_r2y(dir));

    pixel_feed_model pixel_feed_model_inst (.i_clk(i_clk), .o_frame_start(fs), .o_valid(pv),
        .o_p0(p0), .o_p1(p1), .o_p2(p2), .i_res_valid(rv), .i_r0(r0), .i_r1(r1), .i_r2(r2),
        .i_addr(caddr));

    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pix(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge i_clk);
        pen <= 1'b1;
        do
        begin
            @(posedge i_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic setreg(input int i, input logic [31:0] d);
        apb(1'b1, ofs[i], d, 4'hF);
        cur[i] = d & ones[i];
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk_word(nm, e, rd);
        chk_word("slverr", 32'h0, 32'(err));
    endtask

    function automatic logic [7:0] clip(input int v);
        return (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : v[7:0];
    endfunction

    function automatic logic [23:0] y2r(input logic [31:0] a, b, input logic [23:0] p);
        int y, cr, cb, yterm;
        y = int'(p[23:16]) - (b[12] ? 128 : 0);
        cr = int'(p[15:8]) - (b[13] ? 16 : 0);
        cb = int'(p[7:0]) - (b[14] ? 16 : 0);
        yterm = int'(a[7:0]) * y;
        return {clip((yterm + int'(a[15:8]) * cr) >>> 7),
                clip((yterm - int'(a[23:16]) * cr - int'(a[31:24]) * cb) >>> 7),
                clip((yterm + int'(b[8:0]) * cb) >>> 7)};
    endfunction

    function automatic logic [23:0] r2y(input logic [31:0] a, b, c, input logic [23:0] p);
        int r, g, bl;
        r = int'(p[23:16]);
        g = int'(p[15:8]);
        bl = int'(p[7:0]);
        return {clip(((2*int'(a[7:0])*r + 4*int'(a[15:8])*g + int'(a[23:16])*bl) >>> 9)
                     + (a[24] ? 16 : 0)),
                clip(((4*int'(b[7:0])*r - 2*int'(b[15:8])*g - int'(b[23:16])*bl) >>> 9)
                     + (b[24] ? 128 : 0)),
                clip(((4*int'(c[23:16])*bl - int'(c[7:0])*r - 2*int'(c[15:8])*g) >>> 9)
                     + (c[24] ? 128 : 0))};
    endfunction

    // Sends the vector table back to back and checks every result against the matrix.
    task automatic run_vecs(input logic m);
        logic [55:0] got;
        logic [23:0] e;
        pixel_feed_model_inst.res_q.delete();
        foreach (vec[i])
            pixel_feed_model_inst.send(i == 0, vec[i]);
        pixel_feed_model_inst.stop();
        repeat (2) @(posedge i_clk);
        chk_word("result_count", 32'($size(vec)), 32'(pixel_feed_model_inst.res_q.size()));
        foreach (vec[i])
        begin
            got = pixel_feed_model_inst.res_q.pop_front();
            e = m ? r2y(cur[3], cur[4], cur[5], vec[i]) : y2r(cur[1], cur[2], vec[i]);
            chk_pix("pix_0", e[23:16], got[55:48]);
            chk_pix("pix_1", e[15:8], got[47:40]);
            chk_pix("pix_2", e[7:0], got[39:32]);
            if (m)
                chk_word("codec_addr", cur[0] + 32'(4 * i), got[31:0]);
        end
        rchk("pixel_count", OFS_STATUS, 32'($size(vec)));
    endtask

    task automatic t_regs;
        foreach (ofs[i])
            rchk("reset_value", ofs[i], rst[i]);
        rchk("ctrl_reset", OFS_CTRL, 32'h0);
        foreach (ofs[i])
        begin
            setreg(i, 32'hFFFFFFFF);
            rchk("ones", ofs[i], ones[i]);
        end
        apb(1'b1, OFS_CODEC_BASE, 32'h12345678, 4'h3);
        rchk("strobe", OFS_CODEC_BASE, 32'hFFFF5678);
        apb(1'b1, 8'h40, 32'hFFFFFFFF, 4'hF);
        chk_word("unmapped_wr", 32'h1, 32'(err));
        apb(1'b0, 8'h40, 32'h0, 4'h0);
        chk_word("unmapped_rd", 32'h1, 32'(err));
        chk_word("unmapped_data", 32'h0, rd);
        foreach (ofs[i])
            setreg(i, rst[i]);
        $display("test registers done");
    endtask

    task automatic t_y2r;
        run_vecs(1'b0);
        setreg(1, 32'hFF01808F);
        setreg(2, 32'h000001FF);
        run_vecs(1'b0);
        setreg(2, 32'h00001080);
        run_vecs(1'b0);
        setreg(2, 32'h00002080);
        run_vecs(1'b0);
        setreg(2, 32'h00004080);
        run_vecs(1'b0);
        $display("test ycrcb to rgb done");
    endtask

    task automatic t_r2y;
        setreg(0, 32'h10000000);
        apb(1'b1, OFS_CTRL, 32'h1, 4'hF);
        repeat (2) @(posedge i_clk);
        chk_word("dir", 32'h1, 32'(dir));
        run_vecs(1'b1);
        setreg(0, 32'h00000100);
        setreg(3, 32'h00FF01FF);
        setreg(4, 32'h0001FF80);
        setreg(5, 32'h00FF80FF);
        run_vecs(1'b1);
        $display("test rgb to ycrcb done");
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        i_rst_n = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        cur = rst;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_y2r();
        t_r2y();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
